// *** src/eeprom_mem.sv ***
// Purpose: storage array, one write port, registered read port
// Assumes: single clock, no reset on contents
// Notes: read data lags the read address by one clock
`timescale 1ns/1ps
`include "eeprom_params.svh"

module eeprom_mem
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_we, // write strobe
  input wire logic [`ADDR_W-1:0] i_waddr, // write address
  input wire logic [7:0] i_wdata, // write data
  input wire logic [`ADDR_W-1:0] i_raddr, // read address
  output logic [7:0] o_rdata // registered read data
);

  logic [7:0] mem [`DEPTH];

  // ****************************************
  // array access
  // ****************************************
  // contents survive reset, as a non-volatile array must
  always_ff @(posedge i_clk_sys)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule : eeprom_mem

// *** src/eeprom_params.svh ***
// Purpose: named constants for the serial eeprom pin front end
// Assumes: included by bare name, definitions only
// Notes: largest density variant (512 x 8) is built
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// ****************************************
// array geometry
// ****************************************
`define ADDR_W 9
`define DEPTH 512
`define PAGE_BYTES 16
`define PG_IDX_W 4
`define PG_CNT_W 5

// ****************************************
// instruction codes
// ****************************************
`define OPC_READ 8'h03
`define OPC_WRITE 8'h02
`define OPC_MASK 8'hF7
`define OPC_A8_BIT 3

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 25
`define T_WRITE_NS 5000000
`define WAIT_W 18
`define BIT_LAST 3'h7

`endif

// *** src/eeprom_pkg.sv ***
// Purpose: shared types of the serial eeprom pin front end
// Assumes: constants come from eeprom_params.svh
// Notes: none
package eeprom_pkg;

  // ****************************************
  // pin bundle and decode states
  // ****************************************
  typedef struct packed {
    logic sclk;
    logic sel_n;
    logic sdi;
    logic pause_n;
    logic wguard_n;
  } pins_t;

  typedef enum logic [2:0] {
    ST_OPC,
    ST_ADR,
    ST_WR,
    ST_RD,
    ST_IGN
  } st_t;

endpackage : eeprom_pkg

// *** src/serial_eeprom_pin_interface.sv ***
// Purpose: pin front end of a 512 x 8 serial eeprom
// Assumes: pins are asynchronous to i_clk_sys, sampled 2-flop deep
// Notes: serial clock must be slow enough for several sys clocks per phase
// Operation
// - output bit changes only on serial clock falling edges
// - input bit captured on each serial clock rising edge
// - deselected means output pin stays high impedance
// - standby when deselected and idle, active when selected
// - nothing accepted before a select falling edge after reset
// - pause freezes transfer but keeps bit position
// - while paused output is off, clock and data ignored
// - pause only entered while selected
// - write guard low blocks array writes only
// - array is 512 bytes with nine address bits
// - single byte or page of up to sixteen bytes
// - clock to 10 MHz, self-timed write within 5 ms
// - all bytes travel most significant bit first
// - pause starts and ends only while serial clock low
// - deselect during pause resets interface, drops instruction
`timescale 1ns/1ps
`include "eeprom_params.svh"

module serial_eeprom_pin_interface
#(
  parameter int WRITE_CYC = `T_WRITE_NS / `CLK_PERIOD_NS
)
(
  input wire logic i_clk_sys, // system clock, 40 MHz
  input wire logic i_srst, // synchronous reset, high
  input wire logic i_sclk, // serial clock pin
  input wire logic i_sel_n, // select pin, low active
  input wire logic i_sdi, // serial data in pin
  input wire logic i_pause_n, // pause pin, low active
  input wire logic i_wguard_n, // write guard pin, low blocks writes
  output logic o_sdo, // serial data out level
  output logic o_sdo_oe, // serial data out drive enable
  output logic o_active, // active power state
  output logic o_standby, // standby power state
  output logic o_busy // programming cycle running
);

  // ****************************************
  // pin synchronisers and edge finding
  // ****************************************
  eeprom_pkg::pins_t meta_reg, sync_reg, prev_reg, pins;

  always_comb
  begin
    pins.sclk = i_sclk;
    pins.sel_n = i_sel_n;
    pins.sdi = i_sdi;
    pins.pause_n = i_pause_n;
    pins.wguard_n = i_wguard_n;
  end

  // no reset: the chain tracks the pins through reset, so a select
  // held low across release shows no false falling edge
  always_ff @(posedge i_clk_sys)
  begin
    meta_reg <= pins;
    sync_reg <= meta_reg;
    prev_reg <= sync_reg;
  end

  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction : rose

  logic clk_rise, clk_fall, sel_fall, sel_rise;
  assign clk_rise = rose(sync_reg.sclk, prev_reg.sclk);
  assign clk_fall = rose(prev_reg.sclk, sync_reg.sclk);
  assign sel_fall = rose(prev_reg.sel_n, sync_reg.sel_n);
  assign sel_rise = rose(sync_reg.sel_n, prev_reg.sel_n);

  // ****************************************
  // decode state
  // ****************************************
  eeprom_pkg::st_t st_reg, st_next;
  logic armed_reg, armed_next, paused_reg, paused_next;
  logic is_wr_reg, is_wr_next, a8_reg, a8_next;
  logic [2:0] bit_reg, bit_next, obit_reg, obit_next;
  logic [7:0] sh_reg, sh_next, osh_reg, osh_next, byte_in;
  logic [`ADDR_W-1:0] addr_reg, addr_next;
  logic [`PG_IDX_W-1:0] wptr_reg, wptr_next;
  logic [`PAGE_BYTES-1:0] vld_reg, vld_next;
  logic [7:0] pg_reg [`PAGE_BYTES];
  logic [7:0] pg_next [`PAGE_BYTES];
  logic sdo_next, oe_next, act_next, sby_next, sel_ok, run, commit;
  logic [7:0] rdata;

  // programming state
  logic busy_reg, busy_next;
  logic [`PG_CNT_W-1:0] pidx_reg, pidx_next;
  logic [`WAIT_W-1:0] wait_reg, wait_next;
  logic mem_we;

  assign sel_ok = armed_reg & ~sync_reg.sel_n & ~busy_reg;
  assign run = sel_ok & ~paused_reg;
  assign byte_in = {sh_reg[6:0], sync_reg.sdi};
  // whole bytes only, unpaused, guard high: otherwise no array write
  assign commit = sel_rise & armed_reg & ~busy_reg & ~paused_reg
    & (st_reg == eeprom_pkg::ST_WR) & (bit_reg == 3'h0) & (|vld_reg)
    & sync_reg.wguard_n;

  always_comb
  begin
    st_next = st_reg;
    armed_next = armed_reg | sel_fall;
    paused_next = paused_reg;
    is_wr_next = is_wr_reg;
    a8_next = a8_reg;
    bit_next = bit_reg;
    obit_next = obit_reg;
    sh_next = sh_reg;
    osh_next = osh_reg;
    addr_next = addr_reg;
    wptr_next = wptr_reg;
    vld_next = vld_reg;
    pg_next = pg_reg;
    sdo_next = o_sdo;
    // pause follows its pin only while the serial clock sits low
    if (sel_ok & ~sync_reg.sclk)
    begin
      paused_next = ~sync_reg.pause_n;
    end
    if (!sel_ok)
    begin
      // fresh instruction boundary on any deselect
      st_next = eeprom_pkg::ST_OPC;
      paused_next = 1'b0;
      bit_next = 3'h0;
      obit_next = 3'h0;
    end
    else if (run & clk_rise)
    begin
      sh_next = byte_in;
      bit_next = bit_reg + 3'h1;
      if (bit_reg == `BIT_LAST)
      begin
        case (st_reg)
          eeprom_pkg::ST_OPC:
          begin
            a8_next = byte_in[`OPC_A8_BIT];
            is_wr_next = ((byte_in & `OPC_MASK) == `OPC_WRITE);
            if (((byte_in & `OPC_MASK) == `OPC_READ) || is_wr_next)
              st_next = eeprom_pkg::ST_ADR;
            else
              st_next = eeprom_pkg::ST_IGN;
          end
          eeprom_pkg::ST_ADR:
          begin
            addr_next = {a8_reg, byte_in};
            wptr_next = byte_in[`PG_IDX_W-1:0];
            vld_next = '0;
            st_next = is_wr_reg ? eeprom_pkg::ST_WR : eeprom_pkg::ST_RD;
          end
          eeprom_pkg::ST_WR:
          begin
            // bytes past the page end wrap inside the same page
            pg_next[wptr_reg] = byte_in;
            vld_next[wptr_reg] = 1'b1;
            wptr_next = wptr_reg + 4'h1;
          end
          default:
          begin
            st_next = st_reg;
          end
        endcase
      end
    end
    else if (run & clk_fall & (st_reg == eeprom_pkg::ST_RD))
    begin
      obit_next = obit_reg + 3'h1;
      if (obit_reg == 3'h0)
      begin
        osh_next = rdata;
        sdo_next = rdata[7];
        addr_next = addr_reg + 9'h001;
      end
      else
      begin
        osh_next = {osh_reg[6:0], 1'b0};
        sdo_next = osh_reg[6];
      end
    end
    oe_next = run & (st_next == eeprom_pkg::ST_RD);
    act_next = armed_next & ~sync_reg.sel_n;
    sby_next = ~act_next & ~busy_next;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      st_reg <= eeprom_pkg::ST_OPC;
      armed_reg <= 1'b0;
      paused_reg <= 1'b0;
      is_wr_reg <= 1'b0;
      a8_reg <= 1'b0;
      bit_reg <= 3'h0;
      obit_reg <= 3'h0;
      sh_reg <= 8'h00;
      osh_reg <= 8'h00;
      addr_reg <= 9'h000;
      wptr_reg <= 4'h0;
      vld_reg <= 16'h0000;
      pg_reg <= '{default: 8'h00};
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
      o_active <= 1'b0;
      o_standby <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
      armed_reg <= armed_next;
      paused_reg <= paused_next;
      is_wr_reg <= is_wr_next;
      a8_reg <= a8_next;
      bit_reg <= bit_next;
      obit_reg <= obit_next;
      sh_reg <= sh_next;
      osh_reg <= osh_next;
      addr_reg <= addr_next;
      wptr_reg <= wptr_next;
      vld_reg <= vld_next;
      pg_reg <= pg_next;
      o_sdo <= sdo_next;
      o_sdo_oe <= oe_next;
      o_active <= act_next;
      o_standby <= sby_next;
    end
  end

  // ****************************************
  // self-timed programming cycle
  // ****************************************
  // one page byte per clock, while the write time counts from commit
  assign mem_we = busy_reg & ~pidx_reg[`PG_IDX_W]
    & vld_reg[pidx_reg[`PG_IDX_W-1:0]];

  always_comb
  begin
    busy_next = busy_reg;
    pidx_next = pidx_reg;
    wait_next = wait_reg;
    if (commit)
    begin
      busy_next = 1'b1;
      pidx_next = 5'h00;
      wait_next = '0;
    end
    else if (busy_reg)
    begin
      if (!pidx_reg[`PG_IDX_W])
        pidx_next = pidx_reg + 5'h01;
      wait_next = wait_reg + 18'h00001;
      if (wait_reg == WRITE_CYC[`WAIT_W-1:0] - 18'h00001)
        busy_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      busy_reg <= 1'b0;
      pidx_reg <= 5'h00;
      wait_reg <= '0;
      o_busy <= 1'b0;
    end
    else
    begin
      busy_reg <= busy_next;
      pidx_reg <= pidx_next;
      wait_reg <= wait_next;
      o_busy <= busy_next;
    end
  end

  eeprom_mem u_mem
  (
    .i_clk_sys(i_clk_sys),
    .i_we(mem_we),
    .i_waddr({addr_reg[`ADDR_W-1:`PG_IDX_W], pidx_reg[`PG_IDX_W-1:0]}),
    .i_wdata(pg_reg[pidx_reg[`PG_IDX_W-1:0]]),
    .i_raddr(addr_reg),
    .o_rdata(rdata)
  );

endmodule : serial_eeprom_pin_interface

// *** test/eeprom_pins_checker.sv ***
// Purpose: port checks on the serial eeprom pin front end
// Assumes: every serial pin phase lasts at least four sys clocks
// Notes: bound onto the top module after endmodule
`timescale 1ns/1ps

module eeprom_pins_checker
#(
  parameter int WRITE_CYC = 200
)
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_srst, // synchronous reset
  input wire logic i_sclk, // serial clock pin
  input wire logic i_sel_n, // select pin
  input wire logic i_sdi, // serial data in
  input wire logic i_pause_n, // pause pin
  input wire logic i_wguard_n, // write guard pin
  input wire logic o_sdo, // serial data out
  input wire logic o_sdo_oe, // data out enable
  input wire logic o_active, // active power state
  input wire logic o_standby, // standby power state
  input wire logic o_busy // programming running
);
  // ****************************************
  // helper state
  // ****************************************
  logic sel_d_reg;
  logic seen_reg;
  logic seen_next;
  logic [31:0] run_reg;
  logic [31:0] run_next;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  // select fall seen since reset, length of the current busy run
  always_comb
  begin
    seen_next = i_srst ? 1'b0 : (seen_reg | (sel_d_reg & ~i_sel_n));
    run_next = (i_srst || !o_busy) ? 32'h0 : run_reg + 32'h1;
  end

  // sel_d_reg tracks in reset too, so a low held through reset never counts
  always_ff @(posedge i_clk_sys)
  begin
    sel_d_reg <= i_sel_n;
    seen_reg <= seen_next;
    run_reg <= run_next;
  end

  // ****************************************
  // assertions
  // ****************************************
  a_desel_out_off: assert property (i_sel_n [*5] |-> !o_sdo_oe)
    else $error("data out driven while deselected");
  a_sdo_on_fall: assert property ($past(o_sdo_oe, 3) && o_sdo_oe &&
    $changed(o_sdo) |-> !$past(i_sclk, 2))
    else $error("data out moved away from a clock fall");
  a_desel_inactive: assert property (i_sel_n [*5] |-> !o_active)
    else $error("active while deselected");
  a_standby_excl: assert property (o_active || o_busy |-> !o_standby)
    else $error("standby while active or busy");
  a_active_cause: assert property ($rose(o_active) |->
    !i_sel_n && !$past(i_sel_n, 2))
    else $error("active without select low");
  a_armed_first: assert property (o_active |-> seen_reg)
    else $error("active before any select fall");
  a_pause_out_off: assert property (
    (!i_pause_n && !i_sclk && !i_sel_n) [*6] |-> !o_sdo_oe)
    else $error("data out driven while paused");
  a_guard_blocks: assert property ($rose(o_busy) |->
    i_wguard_n && $past(i_wguard_n, 6))
    else $error("programming started with guard low");
  a_busy_length: assert property ($fell(o_busy) |-> run_reg == WRITE_CYC)
    else $error("programming cycle length wrong");
  a_busy_start: assert property ($rose(o_busy) |->
    i_sel_n && $past(i_sel_n, 3))
    else $error("programming began while selected");
endmodule : eeprom_pins_checker

bind serial_eeprom_pin_interface eeprom_pins_checker
  #(.WRITE_CYC(WRITE_CYC)) chk (.*);

// *** test/serial_eeprom_pin_interface_bench.sv ***
// Purpose: self-checking bench for the eeprom pin front end
// Assumes: short programming cycle of 200 sys clocks
// Notes: one task per scenario
`timescale 1ns/1ps
`include "eeprom_params.svh"

module serial_eeprom_pin_interface_bench;
  localparam int WCYC = 200;
  logic i_clk_sys;
  logic i_srst;
  eeprom_pkg::pins_t pins;
  logic o_sdo, o_sdo_oe, o_active, o_standby, o_busy;
  int failures;
  int cmp_count;
  logic [23:0] q;
  logic [7:0] rx;
  logic seen;

  // ****************************************
  // clock, design, master
  // ****************************************
  initial
  begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  serial_eeprom_pin_interface #(.WRITE_CYC(WCYC)) DUT (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_sclk(pins.sclk),
    .i_sel_n(pins.sel_n), .i_sdi(pins.sdi), .i_pause_n(pins.pause_n),
    .i_wguard_n(pins.wguard_n), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe),
    .o_active(o_active), .o_standby(o_standby), .o_busy(o_busy));

  spi_master_model m (.i_clk_sys(i_clk_sys), .i_sdo(o_sdo),
    .i_sdo_oe(o_sdo_oe), .o_pins(pins));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cmd(input logic [7:0] op, input logic [8:0] a);
    m.sel(1'b0);
    m.bits(8, op | ({7'h00, a[8]} << `OPC_A8_BIT), rx);
    m.bits(8, a[7:0], rx);
  endtask : cmd

  // deselect, note any busy, then wait out the programming time
  task automatic done_wr(output logic s);
    m.sel(1'b1);
    s = 1'b0;
    repeat (8)
    begin
      @(posedge i_clk_sys);
      s = s | o_busy;
    end
    repeat (WCYC) @(posedge i_clk_sys);
    check({6'h00, o_busy, o_standby}, 8'h01);
  endtask : done_wr

  task automatic wr(input logic [8:0] a, input logic [23:0] d, input int n);
    cmd(`OPC_WRITE, a);
    for (int i = n - 1; i >= 0; i--)
      m.bits(8, d[8*i +: 8], rx);
    done_wr(seen);
  endtask : wr

  task automatic rd(input logic [8:0] a, input int n);
    q = 24'h0;
    cmd(`OPC_READ, a);
    for (int i = 0; i < n; i++)
    begin
      m.bits(8, 8'h00, rx);
      q = {q[15:0], rx};
    end
    check({6'h00, o_active, o_standby}, 8'h02);
    m.sel(1'b1);
    check({7'h00, o_sdo_oe}, 8'h00);
  endtask : rd

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_unarmed();
    m.bits(8, `OPC_WRITE, rx);
    m.bits(8, 8'hF0, rx);
    m.bits(8, 8'h55, rx);
    check({7'h00, o_active}, 8'h00);
    done_wr(seen);
    check({7'h00, seen}, 8'h00);
    $display("test unarmed done");
  endtask : t_unarmed

  // page write wraps inside the page, read runs up to the array end
  task automatic t_page();
    wr(9'h1FE, 24'hA53C0F, 3);
    check({7'h00, seen}, 8'h01);
    rd(9'h1FE, 2);
    check(q[15:8], 8'hA5);
    check(q[7:0], 8'h3C);
    rd(9'h1F0, 1);
    check(q[7:0], 8'h0F);
    $display("test page done");
  endtask : t_page

  task automatic t_guard();
    m.guard(1'b0);
    wr(9'h1FE, 24'h000000, 1);
    check({7'h00, seen}, 8'h00);
    rd(9'h1FE, 1);
    check(q[7:0], 8'hA5);
    m.guard(1'b1);
    $display("test guard done");
  endtask : t_guard

  // wiggle clock and data while paused; bit position must survive
  task automatic t_pause();
    cmd(`OPC_READ, 9'h1FF);
    m.bits(4, 8'h00, rx);
    q[7:4] = rx[7:4];
    m.hold(1'b0);
    m.tick(8);
    check({7'h00, o_sdo_oe}, 8'h00);
    m.bits(3, 8'hA0, rx);
    m.hold(1'b1);
    m.bits(4, 8'h00, rx);
    q[3:0] = rx[7:4];
    m.sel(1'b1);
    check(q[7:0], 8'h3C);
    $display("test pause done");
  endtask : t_pause

  task automatic t_abort();
    cmd(`OPC_WRITE, 9'h1F0);
    m.bits(8, 8'h11, rx);
    m.bits(4, 8'hFF, rx);
    done_wr(seen);
    check({7'h00, seen}, 8'h00);
    cmd(`OPC_WRITE, 9'h1F0);
    m.bits(8, 8'h22, rx);
    m.hold(1'b0);
    done_wr(seen);
    check({7'h00, seen}, 8'h00);
    m.hold(1'b1);
    rd(9'h1F0, 1);
    check(q[7:0], 8'h0F);
    $display("test abort done");
  endtask : t_abort

  // ****************************************
  // run control
  // ****************************************
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  // whole run is near 3400 clocks; allow ample margin
  initial
  begin
    #1000000;
    failures++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    failures = 0;
    cmp_count = 0;
    i_srst = 1'b1;
    repeat (16) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    @(posedge i_clk_sys);
    t_unarmed();
    t_page();
    t_guard();
    t_pause();
    t_abort();
    end_sim();
  end
endmodule : serial_eeprom_pin_interface_bench

// *** test/spi_master_model.sv ***
// Purpose: serial bus master that drives the eeprom pins
// Assumes: idle-low clock, eight sys clocks per serial bit
// Notes: clock stands low outside frames
`timescale 1ns/1ps

module spi_master_model
(
  input wire logic i_clk_sys, // system clock
  input wire logic i_sdo, // device data out
  input wire logic i_sdo_oe, // device drive enable
  output eeprom_pkg::pins_t o_pins // pins toward device
);
  // ****************************************
  // pin tasks
  // ****************************************
  // select starts low so a low level through reset is exercised
  initial
  begin
    o_pins = 5'b00011;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : tick

  // drive on the low phase, sample mid high phase, msb first
  task automatic bits(input int n, input logic [7:0] tx,
    output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      o_pins.sclk <= 1'b0;
      o_pins.sdi <= tx[i];
      tick(4);
      o_pins.sclk <= 1'b1;
      tick(2);
      rx[i] = i_sdo_oe ? i_sdo : 1'bx;
      tick(2);
    end
  endtask : bits

  // released data line shows the inverse, not a stale level
  task automatic sel(input logic s);
    o_pins.sclk <= 1'b0;
    tick(4);
    o_pins.sel_n <= s;
    if (s)
      o_pins.sdi <= ~o_pins.sdi;
    tick(4);
  endtask : sel

  // pause moves only with clock low; select is left as the caller set it
  task automatic hold(input logic p);
    o_pins.sclk <= 1'b0;
    tick(4);
    o_pins.pause_n <= p;
    tick(4);
  endtask : hold

  task automatic guard(input logic g);
    o_pins.wguard_n <= g;
    tick(4);
  endtask : guard
endmodule : spi_master_model
